// ===== spfa_pkg.sv
// Shared constants and types for the serial flash boot and access sequencer.
// Assumes a core clock of 40 MHz and a link source clock of 180 MHz.
package spfa_pkg;

  // Serial clock divisor range on the link source clock.
  localparam int unsigned LINK_MHZ     = 180;
  localparam int unsigned DIV_W        = 7;
  localparam logic [6:0]  DIV_MIN      = 7'h05;
  localparam logic [6:0]  DIV_MAX      = 7'h7F;

  // Flash addressing covers 128 Mbit, that is 16 Mbyte.
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned ADDR_BYTES   = 3;
  localparam logic [23:0] BOOT_BASE    = 24'h000000;

  // Command opcodes.
  localparam logic [7:0]  OPC_FAST_READ    = 8'h0B;
  localparam logic [7:0]  OPC_STATUS_READ  = 8'h05;
  localparam logic [7:0]  OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0]  OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0]  OPC_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0]  OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0]  OPC_CHIP_ERASE   = 8'hC7;
  localparam logic [7:0]  FILL_BYTE        = 8'h00;
  localparam logic [7:0]  UNLOCK_STATUS    = 8'h00;

  // Status byte layout.
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_LATCH_BIT = 1;
  localparam int unsigned STAT_PROT_LSB  = 2;
  localparam int unsigned STAT_PROT_MSB  = 6;
  localparam int unsigned STAT_LOCK_BIT  = 7;

  // Least deselect time between commands, in link source cycles.
  localparam int unsigned DESEL_NS  = 200;
  localparam int unsigned DESEL_CYC = (DESEL_NS * LINK_MHZ + 999) / 1000;

  typedef enum logic {
    SPFA_TGT_FLASH  = 1'b0,
    SPFA_TGT_SECOND = 1'b1
  } spfa_tgt_t;

  typedef enum logic [2:0] {
    SPFA_OP_READ    = 3'h0,
    SPFA_OP_PROGRAM = 3'h1,
    SPFA_OP_SECTOR  = 3'h2,
    SPFA_OP_CHIP    = 3'h3,
    SPFA_OP_STATUS  = 3'h4,
    SPFA_OP_AUX     = 3'h5,
    SPFA_OP_UNLOCK  = 3'h6,
    SPFA_OP_BOOT    = 3'h7
  } spfa_op_t;

  typedef struct packed {
    spfa_op_t    op;
    logic [23:0] addr;
    logic [7:0]  data;
  } spfa_cmd_t;

  typedef struct packed {
    logic [7:0] tx;
    logic       last;
    spfa_tgt_t  tgt;
    logic [6:0] div;
  } spfa_xfer_t;

endpackage

// ===== spfa_spi_engine.sv
// Byte shifter for the serial flash bus, clocked by the link source clock.
// Assumes the request word stays stable while its toggle is pending.
module spfa_spi_engine (
  input  wire logic                link_clk,
  input  wire logic                core_rst,
  input  wire logic                req_tgl,
  input  spfa_pkg::spfa_xfer_t     xfer,
  output logic                     ack_tgl,
  output logic [7:0]               rx_byte,
  output logic                     serial_clock_out,
  output logic                     serial_clock_oe_n,
  output logic                     serial_data_out,
  output logic                     serial_data_oe_n,
  input  wire logic                serial_data_in,
  output logic                     flash_select_n,
  output logic                     flash_select_oe_n,
  output logic                     second_select_n
);

  typedef enum logic [1:0] {
    SPFA_E_IDLE  = 2'b00,
    SPFA_E_LOW   = 2'b01,
    SPFA_E_HIGH  = 2'b10,
    SPFA_E_DESEL = 2'b11
  } spfa_estate_t;

  spfa_estate_t estate;
  logic         rst_s1, link_rst;
  logic         req_s1, req_s2, req_s3, req_lvl;
  logic         din_s1, din_s2, din_s3, din_lvl;
  logic [7:0]   tx_sh, rx_sh;
  logic [2:0]   bit_idx;
  logic [6:0]   cnt, div_q, lo_cyc, hi_cyc;
  logic         last_q;

  assign hi_cyc = div_q >> 1;
  assign lo_cyc = div_q - hi_cyc;

  // Reset and request toggle arrive from the core clock domain.
  always_ff @(posedge link_clk) begin
    rst_s1   <= core_rst;
    link_rst <= rst_s1;
    req_s1   <= req_tgl;
    req_s2   <= req_s1;
    req_s3   <= req_s2;
    if (req_s2 == req_s3) begin
      req_lvl <= req_s3;
    end
    din_s1 <= serial_data_in;
    din_s2 <= din_s1;
    din_s3 <= din_s2;
    if (din_s2 == din_s3) begin
      din_lvl <= din_s3;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      estate            <= SPFA_E_IDLE;
      serial_clock_out  <= 1'b0;
      serial_data_out   <= 1'b0;
      flash_select_n    <= 1'b1;
      second_select_n   <= 1'b1;
      serial_clock_oe_n <= 1'b1;
      serial_data_oe_n  <= 1'b1;
      flash_select_oe_n <= 1'b1;
      ack_tgl           <= 1'b0;
      rx_byte           <= 8'h00;
      tx_sh             <= 8'h00;
      rx_sh             <= 8'h00;
      bit_idx           <= 3'h0;
      cnt               <= 7'h00;
      div_q             <= spfa_pkg::DIV_MIN;
      last_q            <= 1'b0;
    end else begin
      serial_clock_oe_n <= 1'b0;
      serial_data_oe_n  <= 1'b0;
      flash_select_oe_n <= 1'b0;
      case (estate)
        SPFA_E_IDLE: begin
          if (req_lvl != ack_tgl) begin
            tx_sh           <= xfer.tx;
            serial_data_out <= xfer.tx[7];
            last_q          <= xfer.last;
            div_q           <= xfer.div;
            bit_idx         <= 3'h0;
            cnt             <= 7'h01;
            if (xfer.tgt == spfa_pkg::SPFA_TGT_SECOND) begin
              second_select_n <= 1'b0;
            end else begin
              flash_select_n <= 1'b0;
            end
            estate <= SPFA_E_LOW;
          end
        end
        SPFA_E_LOW: begin
          if (cnt >= lo_cyc) begin
            serial_clock_out <= 1'b1;
            cnt              <= 7'h01;
            estate           <= SPFA_E_HIGH;
          end else begin
            cnt <= cnt + 7'h01;
          end
        end
        SPFA_E_HIGH: begin
          if (cnt >= hi_cyc) begin
            // Launch and capture both happen on the falling edge.
            serial_clock_out <= 1'b0;
            rx_sh            <= {rx_sh[6:0], din_lvl};
            cnt              <= 7'h01;
            if (bit_idx == 3'h7) begin
              rx_byte <= {rx_sh[6:0], din_lvl};
              if (last_q) begin
                flash_select_n  <= 1'b1;
                second_select_n <= 1'b1;
                estate          <= SPFA_E_DESEL;
              end else begin
                ack_tgl <= ~ack_tgl;
                estate  <= SPFA_E_IDLE;
              end
            end else begin
              bit_idx         <= bit_idx + 3'h1;
              tx_sh           <= {tx_sh[6:0], 1'b0};
              serial_data_out <= tx_sh[6];
              estate          <= SPFA_E_LOW;
            end
          end else begin
            cnt <= cnt + 7'h01;
          end
        end
        SPFA_E_DESEL: begin
          // Keeps the select high long enough for the flash to see a new command.
          if (cnt >= 7'(spfa_pkg::DESEL_CYC)) begin
            ack_tgl <= ~ack_tgl;
            estate  <= SPFA_E_IDLE;
          end else begin
            cnt <= cnt + 7'h01;
          end
        end
        default: estate <= SPFA_E_IDLE;
      endcase
    end
  end

endmodule

// ===== spfa_flash_seq.sv
// Serial flash sequencer: boot copy, unlock, auto-init flag and host flash commands.
// Assumes the host drives the command port in the core clock domain and that the
// link source clock feeds link_clk; the pins are resolved outside from the enables.
//
// Behaviour
// - Serial clock is source divided by 5..127.
// - Addresses reach 128 Mbit flash parts.
// - Boot fetch uses only the first select.
// - Boot copies flash code into program memory.
// - Init flag high during auto-init, then low.
// - Host commands accepted only after auto-init.
// - Single data line, clock mode 0.
// - Status bits: busy, latch, protect, lock.
// - Fast read: 0x0B, address, dummy, data.
// - Status read 0x05, write 0x01, one byte.
// - Program 0x02, sector 0x20, chip 0xC7.
// - Boot always unlocks: enable, poll, zero write.
// - Unlock write clears all eight status bits.
// - Enable and poll latch before program, erase.
// - No identification read, no part adaptation.
// - Clock, data, first select float in reset.
// - Second select stays driven during reset.
// - Flash programming on behalf of the host.
// - Two slaves with own selects, up to 36 MHz.
// - Launch and sample on falling clock edges.
module spfa_flash_seq #(
  parameter int unsigned PROG_DEPTH = 256,
  parameter int unsigned PA_W       = $clog2(PROG_DEPTH)
) (
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic                link_clk,
  input  wire logic [6:0]          clk_div,
  input  wire logic                auto_init_done,
  input  wire logic                cmd_valid,
  input  spfa_pkg::spfa_cmd_t      cmd,
  output logic                     cmd_ready,
  output logic                     rsp_valid,
  output logic [7:0]               rsp_data,
  output logic                     init_flag,
  output logic                     init_complete,
  output logic                     boot_active,
  output logic [7:0]               status_byte,
  output logic                     flash_protected,
  output logic                     status_locked,
  input  wire logic [PA_W-1:0]     prog_rd_addr,
  output logic [7:0]               prog_rd_data,
  output logic                     serial_clock_out,
  output logic                     serial_clock_oe_n,
  output logic                     serial_data_out,
  output logic                     serial_data_oe_n,
  input  wire logic                serial_data_in,
  output logic                     flash_select_n,
  output logic                     flash_select_oe_n,
  output logic                     second_select_n
);

  typedef enum logic [3:0] {
    SPFA_S_IDLE     = 4'h0,
    SPFA_S_WRITE_ENABLE_CMD     = 4'h1,
    SPFA_S_STATUS_READ_CMD_OP  = 4'h2,
    SPFA_S_STATUS_READ_CMD_DAT = 4'h3,
    SPFA_S_OPCODE   = 4'h4,
    SPFA_S_ADDR     = 4'h5,
    SPFA_S_DUMMY    = 4'h6,
    SPFA_S_DATA     = 4'h7,
    SPFA_S_AUTOINIT = 4'h8
  } spfa_state_t;

  spfa_state_t                   state;
  spfa_pkg::spfa_op_t            cur_op;
  logic [spfa_pkg::ADDR_BYTES-1:0][7:0] cur_addr;
  logic [7:0]                    cur_data;
  logic                          poll_wel, poll_busy;
  logic [1:0]                    addr_idx;
  logic [PA_W-1:0]               count;
  logic                          booted;

  // Byte request channel toward the link domain.
  spfa_pkg::spfa_xfer_t          xfer;
  logic                          req_tgl, issued;
  logic                          ack_tgl, ack_s1, ack_s2, ack_s3, ack_lvl;
  logic [7:0]                    rx_byte;
  logic                          done;
  logic [7:0]                    tx_byte;
  logic                          tx_last;
  spfa_pkg::spfa_tgt_t           tx_tgt;
  logic                          want_xfer;
  logic [6:0]                    div_eff;
  logic                          accept;

  // Program memory written by the boot copy.
  logic [7:0]                    prog_mem [PROG_DEPTH];

  assign accept = cmd_valid && cmd_ready;
  assign done   = issued && (ack_lvl == req_tgl);
  assign want_xfer = (state != SPFA_S_IDLE) && (state != SPFA_S_AUTOINIT);

  // Out-of-range divisors are clamped rather than refused, so the bus never overclocks.
  always_comb begin
    if (clk_div < spfa_pkg::DIV_MIN) begin
      div_eff = spfa_pkg::DIV_MIN;
    end else begin
      div_eff = clk_div;
    end
  end

  // Byte to send in each state.
  always_comb begin
    tx_byte = spfa_pkg::FILL_BYTE;
    tx_last = 1'b0;
    tx_tgt  = spfa_pkg::SPFA_TGT_FLASH;
    case (state)
      SPFA_S_WRITE_ENABLE_CMD: begin
        tx_byte = spfa_pkg::OPC_WRITE_ENABLE;
        tx_last = 1'b1;
      end
      SPFA_S_STATUS_READ_CMD_OP: begin
        tx_byte = spfa_pkg::OPC_STATUS_READ;
      end
      SPFA_S_STATUS_READ_CMD_DAT: begin
        tx_last = 1'b1;
      end
      SPFA_S_OPCODE: begin
        case (cur_op)
          spfa_pkg::SPFA_OP_READ,
          spfa_pkg::SPFA_OP_BOOT:    tx_byte = spfa_pkg::OPC_FAST_READ;
          spfa_pkg::SPFA_OP_PROGRAM: tx_byte = spfa_pkg::OPC_PAGE_PROGRAM;
          spfa_pkg::SPFA_OP_SECTOR:  tx_byte = spfa_pkg::OPC_SECTOR_ERASE;
          spfa_pkg::SPFA_OP_CHIP: begin
            tx_byte = spfa_pkg::OPC_CHIP_ERASE;
            tx_last = 1'b1;
          end
          spfa_pkg::SPFA_OP_UNLOCK:  tx_byte = spfa_pkg::OPC_STATUS_WRITE;
          spfa_pkg::SPFA_OP_AUX: begin
            tx_byte = cur_data;
            tx_last = 1'b1;
            tx_tgt  = spfa_pkg::SPFA_TGT_SECOND;
          end
          default: tx_byte = spfa_pkg::FILL_BYTE;
        endcase
      end
      SPFA_S_ADDR: begin
        tx_byte = cur_addr[2'(spfa_pkg::ADDR_BYTES - 1) - addr_idx];
        tx_last = (cur_op == spfa_pkg::SPFA_OP_SECTOR)
                  && (addr_idx == 2'(spfa_pkg::ADDR_BYTES - 1));
      end
      SPFA_S_DUMMY: begin
        tx_byte = spfa_pkg::FILL_BYTE;
      end
      SPFA_S_DATA: begin
        case (cur_op)
          spfa_pkg::SPFA_OP_UNLOCK: begin
            tx_byte = spfa_pkg::UNLOCK_STATUS;
            tx_last = 1'b1;
          end
          spfa_pkg::SPFA_OP_PROGRAM: begin
            tx_byte = cur_data;
            tx_last = 1'b1;
          end
          spfa_pkg::SPFA_OP_BOOT: begin
            tx_last = (count == PA_W'(PROG_DEPTH - 1));
          end
          default: tx_last = 1'b1;
        endcase
      end
      default: tx_last = 1'b0;
    endcase
  end

  // Issue one byte per answer, so SPFA_S_ADDR and the boot SPFA_S_DATA send several; the word stays frozen until the engine answers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_tgl <= 1'b0;
      issued  <= 1'b0;
      xfer    <= '0;
    end else if (done) begin
      issued <= 1'b0;
    end else if (!issued && want_xfer) begin
      xfer.tx   <= tx_byte;
      xfer.last <= tx_last;
      xfer.tgt  <= tx_tgt;
      xfer.div  <= div_eff;
      req_tgl   <= ~req_tgl;
      issued    <= 1'b1;
    end
  end

  // Answer toggle from the link domain.
  always_ff @(posedge core_clk) begin
    ack_s1 <= ack_tgl;
    ack_s2 <= ack_s1;
    ack_s3 <= ack_s2;
    if (srst) begin
      ack_lvl <= 1'b0;
    end else if (ack_s2 == ack_s3) begin
      ack_lvl <= ack_s3;
    end
  end

  // Sequencer: boot unlock, boot copy, auto-init and host commands.
  // The flash identity is never read, so timing relies only on clk_div.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state     <= SPFA_S_IDLE;
      cur_op    <= spfa_pkg::SPFA_OP_UNLOCK;
      cur_addr  <= '0;
      cur_data  <= 8'h00;
      poll_wel  <= 1'b0;
      poll_busy <= 1'b0;
      addr_idx  <= 2'h0;
      count     <= '0;
      booted    <= 1'b0;
    end else begin
      case (state)
        SPFA_S_IDLE: begin
          if (!booted) begin
            booted <= 1'b1;
            cur_op <= spfa_pkg::SPFA_OP_UNLOCK;
            state  <= SPFA_S_WRITE_ENABLE_CMD;
          end else if (accept) begin
            cur_op   <= cmd.op;
            cur_addr <= cmd.addr;
            cur_data <= cmd.data;
            case (cmd.op)
              spfa_pkg::SPFA_OP_STATUS: state <= SPFA_S_STATUS_READ_CMD_OP;
              spfa_pkg::SPFA_OP_READ,
              spfa_pkg::SPFA_OP_AUX:    state <= SPFA_S_OPCODE;
              default:                  state <= SPFA_S_WRITE_ENABLE_CMD;
            endcase
          end
        end
        SPFA_S_WRITE_ENABLE_CMD: begin
          if (done) begin
            poll_wel <= 1'b1;
            state    <= SPFA_S_STATUS_READ_CMD_OP;
          end
        end
        SPFA_S_STATUS_READ_CMD_OP: begin
          if (done) begin
            state <= SPFA_S_STATUS_READ_CMD_DAT;
          end
        end
        SPFA_S_STATUS_READ_CMD_DAT: begin
          if (done) begin
            if (poll_wel) begin
              if (rx_byte[spfa_pkg::STAT_LATCH_BIT]) begin
                poll_wel <= 1'b0;
                state    <= SPFA_S_OPCODE;
              end else begin
                state <= SPFA_S_STATUS_READ_CMD_OP;
              end
            end else if (poll_busy) begin
              if (rx_byte[spfa_pkg::STAT_BUSY_BIT]) begin
                state <= SPFA_S_STATUS_READ_CMD_OP;
              end else if (cur_op == spfa_pkg::SPFA_OP_UNLOCK) begin
                poll_busy <= 1'b0;
                cur_op    <= spfa_pkg::SPFA_OP_BOOT;
                cur_addr  <= spfa_pkg::BOOT_BASE;
                state     <= SPFA_S_OPCODE;
              end else begin
                poll_busy <= 1'b0;
                state     <= SPFA_S_IDLE;
              end
            end else begin
              state <= SPFA_S_IDLE;
            end
          end
        end
        SPFA_S_OPCODE: begin
          if (done) begin
            addr_idx <= 2'h0;
            case (cur_op)
              spfa_pkg::SPFA_OP_CHIP: begin
                poll_busy <= 1'b1;
                state     <= SPFA_S_STATUS_READ_CMD_OP;
              end
              spfa_pkg::SPFA_OP_AUX:    state <= SPFA_S_IDLE;
              spfa_pkg::SPFA_OP_UNLOCK: state <= SPFA_S_DATA;
              default:                  state <= SPFA_S_ADDR;
            endcase
          end
        end
        SPFA_S_ADDR: begin
          if (done) begin
            addr_idx <= addr_idx + 2'h1;
            if (addr_idx == 2'(spfa_pkg::ADDR_BYTES - 1)) begin
              case (cur_op)
                spfa_pkg::SPFA_OP_PROGRAM: state <= SPFA_S_DATA;
                spfa_pkg::SPFA_OP_SECTOR: begin
                  poll_busy <= 1'b1;
                  state     <= SPFA_S_STATUS_READ_CMD_OP;
                end
                default: state <= SPFA_S_DUMMY;
              endcase
            end
          end
        end
        SPFA_S_DUMMY: begin
          if (done) begin
            count <= '0;
            state <= SPFA_S_DATA;
          end
        end
        SPFA_S_DATA: begin
          if (done) begin
            case (cur_op)
              spfa_pkg::SPFA_OP_BOOT: begin
                if (count == PA_W'(PROG_DEPTH - 1)) begin
                  state <= SPFA_S_AUTOINIT;
                end else begin
                  count <= count + PA_W'(1);
                end
              end
              spfa_pkg::SPFA_OP_READ: state <= SPFA_S_IDLE;
              default: begin
                poll_busy <= 1'b1;
                state     <= SPFA_S_STATUS_READ_CMD_OP;
              end
            endcase
          end
        end
        SPFA_S_AUTOINIT: begin
          if (auto_init_done) begin
            state <= SPFA_S_IDLE;
          end
        end
        default: state <= SPFA_S_IDLE;
      endcase
    end
  end

  // Boot copy into program memory and its read port.
  always_ff @(posedge core_clk) begin
    if ((state == SPFA_S_DATA) && done && (cur_op == spfa_pkg::SPFA_OP_BOOT)) begin
      prog_mem[count] <= rx_byte;
    end
    prog_rd_data <= prog_mem[prog_rd_addr];
  end

  // Host-facing flags and answers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      init_flag     <= 1'b1;
      init_complete <= 1'b0;
      boot_active   <= 1'b0;
      cmd_ready     <= 1'b0;
      rsp_valid     <= 1'b0;
      rsp_data      <= 8'h00;
    end else begin
      rsp_valid   <= 1'b0;
      boot_active <= !init_complete && (state != SPFA_S_AUTOINIT);
      if ((state == SPFA_S_AUTOINIT) && auto_init_done) begin
        init_flag     <= 1'b0;
        init_complete <= 1'b1;
      end
      cmd_ready <= init_complete && (state == SPFA_S_IDLE) && !accept;
      if (done && (((state == SPFA_S_DATA) && (cur_op == spfa_pkg::SPFA_OP_READ))
          || ((state == SPFA_S_STATUS_READ_CMD_DAT) && !poll_wel && !poll_busy)
          || ((state == SPFA_S_OPCODE) && (cur_op == spfa_pkg::SPFA_OP_AUX)))) begin
        rsp_valid <= 1'b1;
        rsp_data  <= rx_byte;
      end
    end
  end

  // Last status byte seen, decoded for software.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_byte     <= 8'h00;
      flash_protected <= 1'b0;
      status_locked   <= 1'b0;
    end else if ((state == SPFA_S_STATUS_READ_CMD_DAT) && done) begin
      status_byte     <= rx_byte;
      flash_protected <= |rx_byte[spfa_pkg::STAT_PROT_MSB:spfa_pkg::STAT_PROT_LSB];
      status_locked   <= rx_byte[spfa_pkg::STAT_LOCK_BIT];
    end
  end

  spfa_spi_engine u_engine (
    .link_clk          (link_clk),
    .core_rst          (srst),
    .req_tgl           (req_tgl),
    .xfer              (xfer),
    .ack_tgl           (ack_tgl),
    .rx_byte           (rx_byte),
    .serial_clock_out  (serial_clock_out),
    .serial_clock_oe_n (serial_clock_oe_n),
    .serial_data_out   (serial_data_out),
    .serial_data_oe_n  (serial_data_oe_n),
    .serial_data_in    (serial_data_in),
    .flash_select_n    (flash_select_n),
    .flash_select_oe_n (flash_select_oe_n),
    .second_select_n   (second_select_n)
  );

endmodule

// ===== spfa_flash_seq_properties.sv
// Port checks for spfa_flash_seq, bound to its top module.
// Assumes srst is held 8 core cycles before the link side is judged.
module spfa_flash_seq_properties (
  input wire logic       core_clk,
  input wire logic       link_clk,
  input wire logic       srst,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       init_flag,
  input wire logic       init_complete,
  input wire logic [7:0] status_byte,
  input wire logic       flash_protected,
  input wire logic       status_locked,
  input wire logic       serial_clock_out,
  input wire logic       serial_data_out,
  input wire logic       flash_select_n,
  input wire logic       flash_select_oe_n,
  input wire logic       second_select_n
);
  // Link outputs lag srst by a few link cycles, so link checks wait 8 core cycles.
  logic [3:0] since_rst;
  always_ff @(posedge core_clk)
    since_rst <= srst ? 4'h0 : since_rst + {3'h0, !since_rst[3]};
  sequence s_rst; srst [*8]; endsequence
  property p_take; @(posedge core_clk) disable iff (srst)
    cmd_valid && cmd_ready |=> !cmd_ready; endproperty
  a_take: assert property (p_take) else $error("ready held");
  property p_gate; @(posedge core_clk) disable iff (srst)
    cmd_ready |-> init_complete && !init_flag; endproperty
  a_gate: assert property (p_gate) else $error("early ready");
  property p_stat; @(posedge core_clk) disable iff (srst)
    flash_protected == (|status_byte[6:2]) && status_locked == status_byte[7]; endproperty
  a_stat: assert property (p_stat) else $error("status flags");
  // These two judge the reset itself, so reset cannot disable them.
  property p_float; @(posedge core_clk) s_rst |-> flash_select_oe_n; endproperty
  a_float: assert property (p_float) else $error("select driven");
  property p_sel2; @(posedge core_clk) s_rst |-> second_select_n; endproperty
  a_sel2: assert property (p_sel2) else $error("second select");
  property p_idle; @(posedge link_clk) disable iff (srst || !since_rst[3])
    $rose(flash_select_n) |-> !serial_clock_out; endproperty
  a_idle: assert property (p_idle) else $error("clock not idle");
  property p_fall; @(posedge link_clk) disable iff (srst || !since_rst[3])
    !flash_select_n && $changed(serial_data_out) |-> !serial_clock_out; endproperty
  a_fall: assert property (p_fall) else $error("data on rise");
  property p_one; @(posedge link_clk) disable iff (srst || !since_rst[3])
    flash_select_n || second_select_n; endproperty
  a_one: assert property (p_one) else $error("two selects");
endmodule
bind spfa_flash_seq spfa_flash_seq_properties spfa_flash_seq_properties_i (.*);

// ===== spfa_flash_model.sv
// Serial flash model on the first select: 256 bytes, one status byte.
// Assumes mode 0 frames; replies change on falling serial clock edges.
module spfa_flash_model (
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [256];
  logic [7:0]  stat, sh, op, tx;
  logic [23:0] a;
  logic        pe;
  int          nbit, nb, wait_n;
  initial begin
    stat = 8'h9C;
    miso = 1'b0;
    foreach (mem[i])
      mem[i] = 8'(i) ^ 8'h5A;
  end
  always @(negedge cs_n) {nbit, nb} = '0;
  // A released line shows the inverse of its last bit, never a stale copy.
  always @(posedge cs_n) miso = ~miso;
  always @(negedge sclk) if (!cs_n) begin
    miso = tx[7];
    tx = {tx[6:0], ~tx[7]};
  end
  always @(posedge sclk) if (!cs_n) begin
    sh = {sh[6:0], mosi};
    nbit++;
    if (nbit == 8) begin
      nbit = 0;
      op = (nb == 0) ? sh : op;
      wait_n = (op == 8'h06) ? 2 : wait_n;
      if (nb > 0 && nb < 4) a = {a[15:0], sh};
      // The latch shows only on the second poll, so polling is really needed.
      if (op == 8'h05 && nb == 0) begin
        stat[1] = stat[1] | (wait_n == 1);
        wait_n = (wait_n > 0) ? wait_n - 1 : 0;
        tx = stat;
        stat[0] = 1'b0;
      end
      if (op == 8'h01 && nb == 1 && stat[1]) stat = sh & 8'hFD;
      pe = (op == 8'h02 && nb == 4) || (op == 8'h20 && nb == 3) || (op == 8'hC7 && nb == 0);
      if (pe && stat[1] && op == 8'h02) mem[a[7:0]] = sh;
      if (pe && stat[1] && op != 8'h02) mem = '{default: 8'hFF};
      // Busy shows for one poll, so the busy wait loop is really taken.
      if (pe) stat[1:0] = 2'b01;
      if (op == 8'h0B && nb >= 4) begin
        tx = mem[a[7:0]];
        a++;
      end
      nb++;
    end
  end
endmodule

// ===== spfa_flash_seq_bench.sv
// Bench for spfa_flash_seq: boot, auto-init hand-off, host commands, late reset.
// Assumes the flash model on the first select; the second select stays idle.
module spfa_flash_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                core_clk = 1'b0, link_clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0;
  logic                auto_init_done = 1'b0, cmd_ready, rsp_valid, init_flag, init_complete;
  logic                boot_active, flash_protected, status_locked, serial_clock_out;
  logic                serial_clock_oe_n, serial_data_out, serial_data_oe_n, serial_data_in;
  logic                flash_select_n, flash_select_oe_n, second_select_n;
  logic [1:0]          prog_rd_addr = 2'h0;
  logic [2:0]          opl[8] = '{3'h1, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0, 3'h3, 3'h4};
  logic [6:0]          clk_div = 7'h05;
  logic [7:0]          rsp_data, status_byte, prog_rd_data, d, exp_q[$];
  logic [23:0]         a;
  logic [31:0]         lfsr = 32'hE4AC9D43;
  spfa_pkg::spfa_cmd_t cmd = '0;
  int                  n_fail = 0, compares = 0, cycles = 0;
  spfa_flash_seq #(.PROG_DEPTH(4)) spfa_flash_seq_i (.*);
  spfa_flash_model spfa_flash_model_i (.sclk(serial_clock_out & !serial_clock_oe_n),
    .cs_n(flash_select_n | flash_select_oe_n), .mosi(serial_data_out), .miso(serial_data_in));
  always #12.5 core_clk = ~core_clk;
  initial #7 forever #24 link_clk = ~link_clk;
  function automatic logic [31:0] next_lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input logic [2:0] op);
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    clk_div <= 7'h05 + 7'(lfsr[1:0]);
    cmd_valid <= 1'b1;
    cmd <= '{spfa_pkg::spfa_op_t'(op), a, d};
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    if (op == 3'h0 || op == 3'h4) exp_q.push_back(d);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (rsp_valid === 1'b1)
      chk("rsp_data", exp_q.pop_front(), rsp_data);
    if (cycles == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    do @(posedge core_clk); while (boot_active !== 1'b1);
    do @(posedge core_clk); while (boot_active !== 1'b0);
    chk("init_flag", 8'h01, {7'h00, init_flag});
    chk("cmd_ready", 8'h00, {7'h00, cmd_ready});
    chk("status_byte", 8'h00, status_byte);
    for (int i = 0; i < 4; i++) begin
      prog_rd_addr <= 2'(i);
      repeat (2) @(posedge core_clk);
      chk("prog_rd_data", 8'(i) ^ 8'h5A, prog_rd_data);
    end
    $display("boot test done");
    auto_init_done <= 1'b1;
    a = lfsr[23:0];
    foreach (opl[i]) begin
      lfsr = next_lfsr(lfsr);
      if (opl[i] == 3'h1) d = lfsr[7:0];
      if (opl[i] > 3'h1) d = {8{opl[i] != 3'h4}};
      send(opl[i]);
    end
    while (exp_q.size() > 0) @(posedge core_clk);
    chk("init_flag", 8'h00, {7'h00, init_flag});
    $display("command test done");
    srst <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("init_flag", 8'h01, {7'h00, init_flag});
    $display("reset test done");
    complete_run();
  end
endmodule
